// *** rtl/ipfs_pkg.sv ***
package ipfs_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] IPFS_ADDR_CONFIG_A = 8'h2b;
	localparam logic [7:0] IPFS_ADDR_CONFIG_B = 8'h2c;
	localparam logic [7:0] IPFS_ADDR_MONITOR = 8'h2f;
	localparam logic [7:0] IPFS_CONFIG_RESET = 8'h00;
	localparam logic [7:0] IPFS_CONFIG_WMASK = 8'h77;
	// ==========================================================
	// field positions
	localparam int IPFS_HI_FIELD_LSB = 4;
	localparam int IPFS_LO_FIELD_LSB = 0;
	localparam int IPFS_MON_PIN1_BIT = 7;
	localparam int IPFS_NUM_PINS = 4;
	// ==========================================================
	// pin function encoding
	typedef enum logic [2:0] {
		IPFS_FN_DISABLED = 3'h0,
		IPFS_FN_GENERAL = 3'h1,
		IPFS_FN_MCLK = 3'h2,
		IPFS_FN_DAISY = 3'h3,
		IPFS_FN_PDM12 = 3'h4,
		IPFS_FN_PDM34 = 3'h5,
		IPFS_FN_PDM56 = 3'h6,
		IPFS_FN_PDM78 = 3'h7
	} ipfs_func_t;
endpackage : ipfs_pkg

// *** rtl/ipfs_pin_decode.sv ***
`timescale 1ns/1ps
// one pin: decode its function field into per-use qualified levels
module ipfs_pin_decode
	import ipfs_pkg::*;
(
	// selection
	input wire logic [2:0] func,
	input wire logic pin_level,
	// qualified uses
	output logic use_general,
	output logic use_mclk,
	output logic use_daisy,
	output logic [3:0] use_pdm
);
	always_comb begin
		use_general = 1'b0;
		use_mclk = 1'b0;
		use_daisy = 1'b0;
		use_pdm = 4'h0;
		case (ipfs_func_t'(func))
			IPFS_FN_DISABLED: begin
				use_general = 1'b0; // see R9
			end
			IPFS_FN_GENERAL: use_general = pin_level;
			IPFS_FN_MCLK: use_mclk = pin_level;
			IPFS_FN_DAISY: use_daisy = pin_level;
			IPFS_FN_PDM12: use_pdm[0] = pin_level; // see R4
			IPFS_FN_PDM34: use_pdm[1] = pin_level; // see R4
			IPFS_FN_PDM56: use_pdm[2] = pin_level; // see R4
			IPFS_FN_PDM78: use_pdm[3] = pin_level; // see R4
			default: use_general = 1'b0;
		endcase
	end
endmodule : ipfs_pin_decode

// *** rtl/ipfs_top.sv ***
`timescale 1ns/1ps
// Contract
// R1 - pin one function from config_a bits 6-4
// R2 - pin two function from config_a bits 2-0
// R3 - pin three function from config_b bits 6-4
// R4 - values 4-7 select density data pairs
// R5 - both config registers reset to zero
// R6 - bits 7 and 3 read zero
// R7 - pin four function from config_b bits 2-0
// R8 - general input level readable in monitor
// R9 - disabled pin feeds nothing, monitor zero
module ipfs_top
	import ipfs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// control port register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// multiplexed input pins
	input wire logic input_pin_one,
	input wire logic input_pin_two,
	input wire logic input_pin_three,
	input wire logic input_pin_four,
	// routed functions
	output logic mclk_in,
	output logic daisy_chain_serial_input,
	output logic density_data_ch12,
	output logic density_data_ch34,
	output logic density_data_ch56,
	output logic density_data_ch78,
	// current field values
	output logic [2:0] pin_one_function,
	output logic [2:0] pin_two_function,
	output logic [2:0] pin_three_function,
	output logic [2:0] pin_four_function
);
	// ==========================================================
	// write decode
	// only the two config addresses take writes; the monitor and any
	// other address ignore them, so a stray write cannot disturb routing
	// a held strobe just rewrites the same value each cycle
	logic wr_config_a;
	logic wr_config_b;

	assign wr_config_a = reg_wr && (reg_addr == IPFS_ADDR_CONFIG_A);
	assign wr_config_b = reg_wr && (reg_addr == IPFS_ADDR_CONFIG_B);

	// ==========================================================
	// configuration registers
	logic [7:0] input_pin_config_a_reg;
	logic [7:0] input_pin_config_b_reg;

	// reserved bits masked off on write so they always read zero
	// reset leaves every pin disabled until software writes a field
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			input_pin_config_a_reg <= IPFS_CONFIG_RESET; // see R5
		end else if (wr_config_a) begin
			input_pin_config_a_reg <= reg_wdata & IPFS_CONFIG_WMASK; // see R6
		end
	end

	// same layout for the second register, pins three and four
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			input_pin_config_b_reg <= IPFS_CONFIG_RESET; // see R5
		end else if (wr_config_b) begin
			input_pin_config_b_reg <= reg_wdata & IPFS_CONFIG_WMASK; // see R6
		end
	end

	// ==========================================================
	// per-pin decode
	logic [2:0] func [IPFS_NUM_PINS];
	logic [IPFS_NUM_PINS-1:0] pins;
	logic [IPFS_NUM_PINS-1:0] gen_lvl;
	logic [IPFS_NUM_PINS-1:0] mclk_lvl;
	logic [IPFS_NUM_PINS-1:0] daisy_lvl;
	logic [3:0] pdm_lvl [IPFS_NUM_PINS];
	logic [7:0] input_level_monitor;

	assign func[0] = input_pin_config_a_reg[IPFS_HI_FIELD_LSB +: 3]; // see R1
	assign func[1] = input_pin_config_a_reg[IPFS_LO_FIELD_LSB +: 3]; // see R2
	assign func[2] = input_pin_config_b_reg[IPFS_HI_FIELD_LSB +: 3]; // see R3
	assign func[3] = input_pin_config_b_reg[IPFS_LO_FIELD_LSB +: 3]; // see R7
	// pins are taken as already synchronous to clk_sys; a pin driven
	// from another clock must be synchronised before it reaches here
	assign pins = {input_pin_four, input_pin_three, input_pin_two, input_pin_one};

	genvar gi;
	generate
		for (gi = 0; gi < IPFS_NUM_PINS; gi++) begin : g_pin
			ipfs_pin_decode u_dec (
				.func(func[gi]),
				.pin_level(pins[gi]),
				.use_general(gen_lvl[gi]),
				.use_mclk(mclk_lvl[gi]),
				.use_daisy(daisy_lvl[gi]),
				.use_pdm(pdm_lvl[gi])
			);
			// monitor bit: pin one at the top, later pins below it
			assign input_level_monitor[IPFS_MON_PIN1_BIT - gi] = gen_lvl[gi]; // see R8
		end
	endgenerate

	// ==========================================================
	// use collection
	// several pins on one use are or-ed; software should not select that
	logic [3:0] pdm_any;
	genvar gc;

	generate
		for (gc = 0; gc < 4; gc++) begin : g_pair
			assign pdm_any[gc] = pdm_lvl[0][gc] | pdm_lvl[1][gc] | pdm_lvl[2][gc] | pdm_lvl[3][gc]; // see R4
		end
	endgenerate

	// ==========================================================
	// input level monitor
	// levels are taken live at the read edge, not latched, so software
	// sees each general input as it stands when the read is taken
	// low nibble is reserved and reads zero
	assign input_level_monitor[IPFS_MON_PIN1_BIT - IPFS_NUM_PINS:0] = '0;

	// ==========================================================
	// clock and serial uses
	// registered so a routing change cannot glitch the downstream clock
	// or serial path; a clock on a pin is resampled by clk_sys, so only
	// clocks well below half of clk_sys pass through faithfully
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mclk_in <= 1'b0;
		end else begin
			mclk_in <= |mclk_lvl; // see R9
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			daisy_chain_serial_input <= 1'b0;
		end else begin
			daisy_chain_serial_input <= |daisy_lvl; // see R9
		end
	end

	// ==========================================================
	// density data uses
	// channels pair up as 1-2, 3-4, 5-6 and 7-8, one data line each
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			density_data_ch12 <= 1'b0;
			density_data_ch34 <= 1'b0;
			density_data_ch56 <= 1'b0;
			density_data_ch78 <= 1'b0;
		end else begin
			density_data_ch12 <= pdm_any[0]; // see R4
			density_data_ch34 <= pdm_any[1]; // see R4
			density_data_ch56 <= pdm_any[2]; // see R4
			density_data_ch78 <= pdm_any[3]; // see R4
		end
	end

	// ==========================================================
	// field observation
	// each field is shown one cycle after its register, in step with the uses
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_one_function <= 3'h0;
		end else begin
			pin_one_function <= func[0]; // see R1
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_two_function <= 3'h0;
		end else begin
			pin_two_function <= func[1]; // see R2
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_three_function <= 3'h0;
		end else begin
			pin_three_function <= func[2]; // see R3
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pin_four_function <= 3'h0;
		end else begin
			pin_four_function <= func[3]; // see R7
		end
	end

	// ==========================================================
	// register read
	// read data registered; unmapped addresses read zero
	// a read in the same cycle as a write returns the old value
	// monitor is read only; writes to its address fall through the decode
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				IPFS_ADDR_CONFIG_A: reg_rdata <= input_pin_config_a_reg;
				IPFS_ADDR_CONFIG_B: reg_rdata <= input_pin_config_b_reg;
				IPFS_ADDR_MONITOR: reg_rdata <= input_level_monitor; // see R8
				default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule : ipfs_top

// *** verif/ipfs_props.sv ***
`timescale 1ns/1ps
module ipfs_props (
	// clock, reset, access
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// pins and uses
	input wire logic input_pin_one,
	input wire logic input_pin_two,
	input wire logic input_pin_three,
	input wire logic input_pin_four,
	input wire logic mclk_in,
	input wire logic daisy_chain_serial_input,
	input wire logic density_data_ch12,
	input wire logic density_data_ch34,
	input wire logic density_data_ch56,
	input wire logic density_data_ch78,
	input wire logic [2:0] pin_one_function,
	input wire logic [2:0] pin_two_function,
	input wire logic [2:0] pin_three_function,
	input wire logic [2:0] pin_four_function
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [3:0] lvl_q;
	logic [7:0] hit;
	// ==========
	// expected uses: levels one cycle old, fields as shown
	always_ff @(posedge clk_sys) lvl_q <= {input_pin_four, input_pin_three, input_pin_two, input_pin_one};
	always_comb begin
		hit = 8'h00;
		hit[pin_one_function] |= lvl_q[0];
		hit[pin_two_function] |= lvl_q[1];
		hit[pin_three_function] |= lvl_q[2];
		hit[pin_four_function] |= lvl_q[3];
	end
	sequence s_wr_a; reg_wr && reg_addr == 8'h2b; endsequence
	sequence s_wr_b; reg_wr && reg_addr == 8'h2c; endsequence
	a_mclk_route: assert property (mclk_in == hit[2]) else $error("mclk use wrong");
	a_daisy_route: assert property (daisy_chain_serial_input == hit[3]) else $error("daisy use wrong");
	a_pdm_route: assert property ({density_data_ch78, density_data_ch56, density_data_ch34, density_data_ch12}
		== hit[7:4]) else $error("density use wrong");
	a_one_field: assert property (s_wr_a |-> ##2 pin_one_function == 3'($past(reg_wdata, 2) >> 4))
		else $error("pin one field");
	a_two_field: assert property (s_wr_a |-> ##2 pin_two_function == 3'($past(reg_wdata, 2)))
		else $error("pin two field");
	a_three_field: assert property (s_wr_b |-> ##2 pin_three_function == 3'($past(reg_wdata, 2) >> 4))
		else $error("pin three field");
	a_four_field: assert property (s_wr_b |-> ##2 pin_four_function == 3'($past(reg_wdata, 2)))
		else $error("pin four field");
	a_reserved_zero: assert property ((reg_rd && (reg_addr == 8'h2b || reg_addr == 8'h2c))
		|=> (reg_rdata & 8'h88) == 8'h00) else $error("reserved bit set");
	a_monitor_low: assert property ((reg_rd && reg_addr == 8'h2f) |=> reg_rdata[3:0] == 4'h0)
		else $error("monitor low nibble set");
endmodule : ipfs_props
bind ipfs_top ipfs_props props_u (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
	.input_pin_one, .input_pin_two, .input_pin_three, .input_pin_four, .mclk_in, .daisy_chain_serial_input,
	.density_data_ch12, .density_data_ch34, .density_data_ch56, .density_data_ch78,
	.pin_one_function, .pin_two_function, .pin_three_function, .pin_four_function);

// *** verif/input_pin_function_select_test.sv ***
`timescale 1ns/1ps
module input_pin_function_select_test;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [3:0] pins = 4'h0;
	wire logic [5:0] routed;
	int checks = 0;
	int mismatches = 0;
	ipfs_top dut_u (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
		.input_pin_one(pins[0]), .input_pin_two(pins[1]), .input_pin_three(pins[2]), .input_pin_four(pins[3]),
		.mclk_in(routed[0]), .daisy_chain_serial_input(routed[1]), .density_data_ch12(routed[2]),
		.density_data_ch34(routed[3]), .density_data_ch56(routed[4]), .density_data_ch78(routed[5]),
		.pin_one_function(), .pin_two_function(), .pin_three_function(), .pin_four_function());
	initial forever #4 clk_sys = ~clk_sys;
	// ==========
	// access tasks, driven on the falling edge
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		chk(reg_rdata, exp);
	endtask : rd
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report
	// ==========
	// tests
	initial begin
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		rd(8'h2b, 8'h00);
		rd(8'h2c, 8'h00);
		wr(8'h2b, 8'hff);
		wr(8'h2c, 8'hff);
		rd(8'h2b, 8'h77);
		rd(8'h2c, 8'h77);
		rd(8'h30, 8'h00);
		// every code on every pin, only the pin under test high
		for (int p = 0; p < 4; p++) begin
			for (int k = 0; k < 8; k++) begin
				pins = 4'h1 << p;
				wr(p < 2 ? 8'h2b : 8'h2c, p[0] ? 8'(k) : 8'(k << 4));
				repeat (2) @(negedge clk_sys);
				chk({2'b00, routed}, k > 1 ? 8'(1 << (k - 2)) : 8'h00);
				rd(8'h2f, k == 1 ? 8'h80 >> p : 8'h00);
				// pin back low: every use and the monitor must follow it down
				pins = 4'h0;
				repeat (2) @(negedge clk_sys);
				chk({2'b00, routed}, 8'h00);
				rd(8'h2f, 8'h00);
			end
		end
		// reset in mid-run must clear what the loop left behind
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		rd(8'h2b, 8'h00);
		rd(8'h2c, 8'h00);
		final_report();
	end
	initial begin
		repeat (2000) @(posedge clk_sys);
		mismatches++;
		final_report();
	end
endmodule : input_pin_function_select_test
